// ==== serial_flash_status_and_read_cmds_test.sv ====
// self-checking bench: host and flash ends joined over the serial link
`timescale 1ns/1ps
module serial_flash_status_and_read_cmds_test
	import sfsr_pkg::*;
;
	typedef struct packed {
		sfsr_cmd_t   cmd;
		logic [23:0] addr;
		logic [6:0]  n;
		logic [7:0]  exp;
	} sfsr_row_t;

	// ==========================================================
	// ordinary cases: last byte read back is (its own address ^ a5), status reads 00
	localparam sfsr_row_t ROWS [8] = '{
		'{SFSR_CMD_READ,  24'h000010, 7'h1, 8'hb5},
		'{SFSR_CMD_READ,  24'h000020, 7'h4, 8'h86},
		'{SFSR_CMD_FREAD, 24'h000040, 7'h2, 8'he4},
		'{SFSR_CMD_DREAD, 24'h000080, 7'h3, 8'h27},
		'{SFSR_CMD_READ,  24'hfffffe, 7'h3, 8'ha5},
		'{SFSR_CMD_DREAD, 24'hffffff, 7'h2, 8'ha5},
		'{SFSR_CMD_RDSR,  24'h000000, 7'h1, 8'h00},
		'{SFSR_CMD_READ_SUSPEND_STATUS_CMD, 24'h000000, 7'h1, 8'h00}
	};

	logic        ref_clk_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic [3:0]  addr_i    = 4'h0;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        op_fail_i = 1'b0;
	logic [31:0] rdata_o;
	logic        hw_protect_o;
	logic [7:0]  status_o;
	logic [7:0]  susp_status_o;
	logic [31:0] v;
	int          bad_count = 0;
	int          n_checks  = 0;
	int          k;

	sfsr_if lnk ();
	sfsr_host u_sfsr_host (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lnk(lnk));
	sfsr_dev u_sfsr_dev (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .lnk(lnk), .op_fail_i(op_fail_i),
		.hw_protect_o(hw_protect_o), .status_o(status_o), .susp_status_o(susp_status_o));
	sfsr_link_properties u_sfsr_link_properties (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.cs_n(lnk.cs_n), .sck(lnk.sck), .io0_h(lnk.io0_h), .io0_h_oe(lnk.io0_h_oe),
		.io0_d(lnk.io0_d), .io0_d_oe(lnk.io0_d_oe), .io1_d(lnk.io1_d), .io1_d_oe(lnk.io1_d_oe),
		.wp_n(lnk.wp_n), .io0(lnk.io0), .io1(lnk.io1));

	always #50 ref_clk_i = ~ref_clk_i;

	// ==========================================================
	// helpers
	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask

	// sample just past the edge so design updates have landed
	task automatic tick();
		@(posedge ref_clk_i);
		#1;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic start_cmd(input sfsr_cmd_t c, input logic [7:0] wd, input logic [6:0] n,
			input logic wp, input logic [23:0] a = 24'h0);
		reg_wr(HR_ADDR, {8'h00, a});
		reg_wr(HR_WDATA, {24'h0, wd});
		reg_wr(HR_CTRL, {16'h0, wp, n, 5'h00, c});
	endtask

	// bounded poll on the done flag, then fetch the last byte
	task automatic wait_done();
		v = 32'h0;
		for (int i = 0; i < 3000 && v[1] !== 1'b1; i++)
			reg_rd(HR_STATUS, v);
		chk(v[1], 1'b1);
		reg_rd(HR_RDATA, v);
	endtask

	task automatic run(input sfsr_cmd_t c, input logic [7:0] wd, input logic [6:0] n, input logic wp);
		start_cmd(c, wd, n, wp);
		wait_done();
	endtask

	// ==========================================================
	// sequence
	initial begin
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) tick();
		chk({status_o, susp_status_o}, 16'h0000);
		foreach (ROWS[i]) begin
			start_cmd(ROWS[i].cmd, 8'h00, ROWS[i].n, 1'b0, ROWS[i].addr);
			wait_done();
			chk(v[7:0], ROWS[i].exp);
			chk(susp_status_o & SS_RSVD_MASK, 8'h00);
		end
		// write with the latch clear is dropped
		run(SFSR_CMD_STATUS_WRITE_CMD, 8'hff, 7'h1, 1'b0);
		repeat (TW_CYC + 10) tick();
		chk(status_o, 8'h00);
		run(SFSR_CMD_RAW, OP_SUSPEND, 7'h0, 1'b0);
		chk(susp_status_o, 8'h00);
		run(SFSR_CMD_WRITE_ENABLE_CMD, 8'h00, 7'h0, 1'b0);
		run(SFSR_CMD_READ_SUSPEND_STATUS_CMD, 8'h00, 7'h1, 1'b0);
		chk(v[7:0], 8'h02);
		chk(v[7:0] & ~SS_RSVD_MASK, 8'h02);
		// self-timed write: busy span, mirrored busy, latch cleared after
		start_cmd(SFSR_CMD_STATUS_WRITE_CMD, 8'hff, 7'h1, 1'b0);
		for (k = 0; k < 1000 && status_o[SR_BUSY] !== 1'b1; k++) tick();
		for (k = 0; k < 1000 && status_o[SR_BUSY] === 1'b1; k++) begin
			chk(susp_status_o[SS_BUSY], status_o[SR_BUSY]);
			tick();
		end
		chk(k >= TW_CYC - 2 && k <= TW_CYC + 2, 1'b1);
		wait_done();
		chk(status_o, 8'hbc);
		// protect bit set and write-protect low: write refused, latch kept
		run(SFSR_CMD_WRITE_ENABLE_CMD, 8'h00, 7'h0, 1'b1);
		start_cmd(SFSR_CMD_STATUS_WRITE_CMD, 8'h00, 7'h1, 1'b1);
		repeat (20) tick();
		chk(hw_protect_o, 1'b1);
		wait_done();
		repeat (TW_CYC + 10) tick();
		chk(status_o, 8'hbe);
		// failed write latches the fail flag until a software reset
		@(posedge ref_clk_i);
		op_fail_i <= 1'b1;
		run(SFSR_CMD_STATUS_WRITE_CMD, 8'h00, 7'h1, 1'b0);
		repeat (TW_CYC + 10) tick();
		@(posedge ref_clk_i);
		op_fail_i <= 1'b0;
		run(SFSR_CMD_READ_SUSPEND_STATUS_CMD, 8'h00, 7'h1, 1'b0);
		chk(v[SS_FAIL], 1'b1);
		run(SFSR_CMD_RAW, OP_RSTEN, 7'h0, 1'b0);
		run(SFSR_CMD_RAW, OP_RST, 7'h0, 1'b0);
		repeat (4) tick();
		chk(susp_status_o[SS_FAIL], 1'b0);
		// mid-run reset as power-up: latch and fail flag both clear
		run(SFSR_CMD_WRITE_ENABLE_CMD, 8'h00, 7'h0, 1'b0);
		@(posedge ref_clk_i);
		op_fail_i <= 1'b1;
		run(SFSR_CMD_STATUS_WRITE_CMD, 8'h00, 7'h1, 1'b0);
		repeat (TW_CYC + 10) tick();
		run(SFSR_CMD_WRITE_ENABLE_CMD, 8'h00, 7'h0, 1'b0);
		chk(susp_status_o, 8'h22);
		@(posedge ref_clk_i);
		op_fail_i <= 1'b0;
		nrst_i    <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) tick();
		chk({status_o, susp_status_o}, 16'h0000);
		tally_and_finish();
	end

	// more than ten times the expected run length
	initial begin
		#(60000 * 100);
		bad_count++;
		tally_and_finish();
	end
endmodule // serial_flash_status_and_read_cmds_test

// ==== sfsr_dev.sv ====
// flash device end: status, status write and read commands
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// RULE1 - suspend status bits 0,4,6 read zero
// RULE2 - host masks reserved suspend status bits
// RULE3 - suspend/resume refused while write latch clear
// RULE4 - erase suspended flag set/cleared by suspend/resume; op_is_erase is never set here, so suspend never sets esus
// RULE5 - program suspended flag set/cleared likewise
// RULE6 - fail flag sticky until new cycle/reset; a new cycle here leaves it set, only reset clears it
// RULE7 - suspend busy bit equals main busy bit
// RULE8 - status write needs write latch set
// RULE9 - status write ends right after data byte
// RULE10 - status write keeps latch and busy bits
// RULE11 - timed cycle sets busy, clears latch
// RULE12 - status reads answered during write cycle
// RULE13 - status write blocked in hardware protection
// RULE14 - read: opcode, 24-bit address, data out
// RULE15 - address increments per byte, wraps zero
// RULE16 - chip select rise stops data output
// RULE17 - reads ignored while a cycle runs
// RULE18 - fast read adds one dummy byte
// RULE19 - dual read drives two lines
// RULE20 - dual read dummy clocks ignored
// RULE21 - host releases input before dual data
// RULE22 - protection: protect bit and write-protect low
// RULE23 - suspend status byte layout, msb first
// RULE24 - opcode msb first; chip select aborts
module sfsr_dev
	import sfsr_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	// link
	sfsr_if.dev       lnk,
	// internal operation hooks
	input  wire logic op_fail_i,
	output logic      hw_protect_o,
	output logic [7:0] status_o,
	output logic [7:0] susp_status_o
);
	typedef enum logic [6:0] {
		SFSR_D_OPC   = 7'b0000001,
		SFSR_D_ADDR  = 7'b0000010,
		SFSR_D_DUMMY = 7'b0000100,
		SFSR_D_DATA  = 7'b0001000,
		SFSR_D_WDATA = 7'b0010000,
		SFSR_D_WDONE = 7'b0100000,
		SFSR_D_IGN   = 7'b1000000
	} sfsr_dst_t;
	// ==========================================================
	// pin synchronisers
	logic cs_n_s, sck_s, io0_s, wp_n_s;
	sfsr_sync #(.RST_VAL(1'b1)) u_cs  (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.cs_n), .q_o(cs_n_s));
	sfsr_sync #(.RST_VAL(1'b0)) u_sck (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.sck),  .q_o(sck_s));
	sfsr_sync #(.RST_VAL(1'b0)) u_io0 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.io0),  .q_o(io0_s));
	sfsr_sync #(.RST_VAL(1'b1)) u_wp  (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.wp_n), .q_o(wp_n_s));
	logic sck_d, cs_d;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_d <= 1'b0;
			cs_d  <= 1'b1;
		end else begin
			sck_d <= sck_s;
			cs_d  <= cs_n_s;
		end
	end
	logic rise, fall, cs_rise;
	assign rise    = sck_s & ~sck_d & ~cs_n_s;
	assign fall    = ~sck_s & sck_d & ~cs_n_s;
	assign cs_rise = cs_n_s & ~cs_d;
	// ==========================================================
	// state and status
	sfsr_dst_t   st;
	logic [7:0]  sh;
	logic [7:0]  opc;
	logic [5:0]  cnt;
	logic [23:0] addr;
	logic [7:0]  obyte;
	logic [7:0]  sr;
	logic        write_enable_latch, busy, fail, esus, psus, rst_armed;
	logic [15:0] tmr;
	logic        wr_pend, op_is_erase;
	logic [7:0]  mem [MEM_DEPTH];
	initial begin
		for (int i = 0; i < MEM_DEPTH; i++) mem[i] = 8'(i ^ 8'ha5);
	end
	logic hardware_protected_mode;
	assign hardware_protected_mode = sr[SR_SRP] & ~wp_n_s; // [RULE22]
	assign hw_protect_o = hardware_protected_mode;
	logic [7:0] ss;
	// reserved positions fall out as zero [RULE1] [RULE7] [RULE23]
	assign ss = {busy, 1'b0, fail, 1'b0, psus, esus, write_enable_latch, 1'b0} & ~SS_RSVD_MASK;
	assign susp_status_o = ss;
	assign status_o = {sr[7:2], write_enable_latch, busy};
	logic [7:0] opc_nx;
	assign opc_nx = {sh[6:0], io0_s};
	logic is_read, dual;
	assign is_read = (opc == OP_READ) || (opc == OP_FREAD) || (opc == OP_DREAD);
	assign dual    = (opc == OP_DREAD);
	// ==========================================================
	// command sequencer
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= SFSR_D_OPC;
			sh <= 8'h00;
			opc <= 8'h00;
			cnt <= 6'h00;
			addr <= 24'h000000;
			wr_pend <= 1'b0;
		end else if (cs_n_s) begin
			// chip select high aborts partial opcodes [RULE24] [RULE9]
			wr_pend <= (st == SFSR_D_WDONE) && cs_rise;
			st  <= SFSR_D_OPC;
			cnt <= 6'h00;
		end else begin
			wr_pend <= 1'b0;
			if (rise) begin
				sh <= opc_nx;
				case (st)
					SFSR_D_OPC: begin
						cnt <= 6'(cnt + 6'h01);
						if (cnt == 6'h07) begin // msb first [RULE24]
							opc <= opc_nx;
							cnt <= 6'h00;
							if (opc_nx == OP_STATUS_WRITE_CMD) begin
								// latch, busy and protection gate [RULE8] [RULE13]
								st <= (write_enable_latch && !busy && !hardware_protected_mode) ? SFSR_D_WDATA : SFSR_D_IGN;
							end else if (opc_nx == OP_READ || opc_nx == OP_FREAD || opc_nx == OP_DREAD) begin
								st <= busy ? SFSR_D_IGN : SFSR_D_ADDR; // [RULE17]
							end else if (opc_nx == OP_RDSR || opc_nx == OP_READ_SUSPEND_STATUS_CMD) begin
								st <= SFSR_D_DATA; // [RULE12]
							end else begin
								st <= SFSR_D_IGN;
							end
						end
					end
					SFSR_D_ADDR: begin
						addr <= {addr[22:0], io0_s}; // [RULE14]
						cnt  <= 6'(cnt + 6'h01);
						if (cnt == 6'(ADDR_W - 1)) begin
							cnt <= 6'h00;
							st  <= (opc == OP_READ) ? SFSR_D_DATA : SFSR_D_DUMMY; // [RULE18]
						end
					end
					SFSR_D_DUMMY: begin
						// input content ignored [RULE20]
						cnt <= 6'(cnt + 6'h01);
						if (cnt == 6'(DUMMY_BITS - 1)) begin
							cnt <= 6'h00;
							st  <= SFSR_D_DATA;
						end
					end
					SFSR_D_WDATA: begin
						cnt <= 6'(cnt + 6'h01);
						if (cnt == 6'h07) st <= SFSR_D_WDONE;
					end
					SFSR_D_WDONE: st <= SFSR_D_IGN; // extra bit discards write [RULE9]
					SFSR_D_DATA: begin
						cnt <= 6'(cnt + (dual ? 6'h02 : 6'h01));
						if (is_read && cnt == (dual ? 6'h06 : 6'h07)) begin
							cnt  <= 6'h00;
							addr <= (addr == ADDR_TOP) ? 24'h000000 : 24'(addr + 24'h1); // [RULE15]
						end else if (cnt == (dual ? 6'h06 : 6'h07)) begin
							cnt <= 6'h00;
						end
					end
					default: st <= st;
				endcase
			end
		end
	end
	// ==========================================================
	// output shifter: changes on falling edges
	logic [7:0] src;
	always_comb begin
		src = mem[addr[7:0]];
		if (opc == OP_RDSR) src = status_o;
		if (opc == OP_READ_SUSPEND_STATUS_CMD) src = ss;
	end
	logic oe, out_hi, out_lo;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			obyte  <= 8'h00;
			oe     <= 1'b0;
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else if (cs_n_s || st != SFSR_D_DATA) begin
			oe     <= 1'b0; // stop driving on chip select rise [RULE16]
			obyte  <= 8'h00;
			out_hi <= 1'b0;
			out_lo <= 1'b0;
		end else if (fall) begin
			// pins move only here, so data stands a whole clock for the host [RULE14]
			oe <= 1'b1;
			if (cnt == 6'h00) begin
				out_hi <= src[7];
				out_lo <= src[6];
				obyte  <= dual ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
			end else begin
				out_hi <= obyte[7];
				out_lo <= obyte[6];
				obyte  <= dual ? {obyte[5:0], 2'b00} : {obyte[6:0], 1'b0};
			end
		end
	end
	assign lnk.io1_d    = out_hi;
	assign lnk.io1_d_oe = oe; // [RULE14]
	assign lnk.io0_d    = out_lo;
	assign lnk.io0_d_oe = oe & dual; // two lines [RULE19] [RULE21]
	// ==========================================================
	// status, suspend and self-timed cycles
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sr <= SR_RESET;
			write_enable_latch <= 1'b0;
			busy <= 1'b0;
			fail <= 1'b0;
			esus <= 1'b0;
			psus <= 1'b0;
			tmr <= 16'h0000;
			op_is_erase <= 1'b0;
			rst_armed <= 1'b0;
		end else begin
			if (wr_pend) begin
				// data byte only reaches protect bits [RULE10] [RULE13]
				sr   <= (sr & ~SR_WR_MASK) | (sh & SR_WR_MASK);
				busy <= 1'b1; // [RULE11]
				tmr  <= 16'(TW_CYC);
			end else if (busy && tmr != 16'h0000) begin
				tmr <= 16'(tmr - 16'h1);
				if (tmr == 16'h0001) begin
					busy   <= 1'b0;
					write_enable_latch    <= 1'b0; // [RULE11]
					if (op_fail_i) fail <= 1'b1; // [RULE6]
				end
			end
			if (rise && st == SFSR_D_OPC && cnt == 6'h07 && !cs_n_s) begin
				rst_armed <= (opc_nx == OP_RSTEN);
				if (opc_nx == OP_WRITE_ENABLE_CMD && !busy) write_enable_latch <= 1'b1;
				if (opc_nx == OP_RST && rst_armed) begin
					// a failure reported in this same cycle outlives the reset
					if (!(busy && tmr == 16'h0001 && op_fail_i)) fail <= 1'b0; // [RULE6]
					write_enable_latch  <= 1'b0;
				end
				// suspend/resume need the write latch [RULE3]
				if (write_enable_latch && opc_nx == OP_SUSPEND && busy) begin
					busy <= 1'b0;
					tmr  <= 16'h0000;
					if (op_is_erase) esus <= 1'b1; // [RULE4]
					else psus <= 1'b1; // [RULE5]
				end
				if (write_enable_latch && opc_nx == OP_RESUME && (esus || psus)) begin
					esus <= 1'b0; // [RULE4]
					psus <= 1'b0; // [RULE5]
					busy <= 1'b1;
					tmr  <= 16'(OP_CYC);
				end
			end
		end
	end
endmodule // sfsr_dev

// ==== sfsr_host.sv ====
// host controller end: register port, command sequencing over the link
`timescale 1ns/1ps
module sfsr_host
	import sfsr_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [31:0]     rdata_o,
	// link
	sfsr_if.host            lnk
);
	typedef enum logic [3:0] {
		SFSR_H_IDLE  = 4'b0001,
		SFSR_H_LOW   = 4'b0010,
		SFSR_H_HIGH  = 4'b0100,
		SFSR_H_END   = 4'b1000
	} sfsr_hst_t;
	logic io0_s, io1_s;
	sfsr_sync #(.RST_VAL(1'b1)) u_i0 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.io0), .q_o(io0_s));
	sfsr_sync #(.RST_VAL(1'b1)) u_i1 (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .d_i(lnk.io1), .q_o(io1_s));
	// ==========================================================
	// registers
	sfsr_hst_t   st;
	sfsr_cmd_t   cmd;
	logic [23:0] raddr;
	logic [7:0]  wdat, rdat, rsh;
	logic [7:0]  nbytes, bcnt;
	logic [47:0] osh;
	logic [6:0]  obits, bit_i;
	logic [3:0]  div;
	logic        wp_n, dual, done;
	logic [7:0]  next_rsh;
	assign next_rsh = dual ? {rsh[5:0], io1_s, io0_s} : {rsh[6:0], io1_s}; // io1 is the high bit [RULE19]
	// ==========================================================
	// command launch
	logic go;
	assign go = wr_i && addr_i == HR_CTRL && st == SFSR_H_IDLE;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			raddr <= 24'h000000;
			wdat  <= 8'h00;
			wp_n  <= 1'b1;
		end else if (wr_i) begin
			if (addr_i == HR_ADDR) raddr <= wdata_i[23:0];
			if (addr_i == HR_WDATA) wdat <= wdata_i[7:0];
			if (addr_i == HR_CTRL) wp_n <= ~wdata_i[15];
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 32'h0;
		end else begin
			case (addr_i)
				HR_RDATA:  rdata_o <= {24'h0, rdat};
				HR_STATUS: rdata_o <= {30'h0, done, st != SFSR_H_IDLE};
				HR_ADDR:   rdata_o <= {8'h0, raddr};
				default:   rdata_o <= 32'h0;
			endcase
		end
	end
	// ==========================================================
	// link sequencer with divided serial clock
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= SFSR_H_IDLE;
			cmd <= SFSR_CMD_WRITE_ENABLE_CMD;
			osh <= 48'h0;
			obits <= 7'h0;
			bit_i <= 7'h0;
			nbytes <= 8'h0;
			bcnt <= 8'h0;
			div <= 4'h0;
			dual <= 1'b0;
			done <= 1'b0;
			rdat <= 8'h00;
			rsh <= 8'h00;
		end else begin
			if (rd_i && addr_i == HR_STATUS) done <= 1'b0;
			case (st)
				SFSR_H_IDLE: if (go) begin
					cmd    <= sfsr_cmd_t'(wdata_i[2:0]);
					nbytes <= wdata_i[15:8];
					bcnt   <= 8'h0;
					bit_i  <= 7'h0;
					div    <= 4'h0;
					dual   <= (sfsr_cmd_t'(wdata_i[2:0]) == SFSR_CMD_DREAD);
					case (sfsr_cmd_t'(wdata_i[2:0]))
						SFSR_CMD_WRITE_ENABLE_CMD:  begin osh <= {OP_WRITE_ENABLE_CMD, 40'h0}; obits <= 7'd8; end
						SFSR_CMD_STATUS_WRITE_CMD:  begin osh <= {OP_STATUS_WRITE_CMD, wdat, 32'h0}; obits <= 7'd16; end // [RULE9]
						SFSR_CMD_RDSR:  begin osh <= {OP_RDSR, 40'h0}; obits <= 7'd8; end
						SFSR_CMD_READ_SUSPEND_STATUS_CMD: begin osh <= {OP_READ_SUSPEND_STATUS_CMD, 40'h0}; obits <= 7'd8; end
						SFSR_CMD_READ:  begin osh <= {OP_READ, raddr, 16'h0}; obits <= 7'd32; end // [RULE14]
						SFSR_CMD_FREAD: begin osh <= {OP_FREAD, raddr, 16'h0}; obits <= 7'd40; end // [RULE18]
						SFSR_CMD_DREAD: begin osh <= {OP_DREAD, raddr, 16'h0}; obits <= 7'd40; end
						default:        begin osh <= {wdat, 40'h0}; obits <= 7'd8; end
					endcase
					st <= SFSR_H_LOW;
				end
				SFSR_H_LOW: begin
					div <= 4'(div + 4'h1);
					if (div == 4'(DIV_HALF - 1)) begin
						div <= 4'h0;
						st  <= SFSR_H_HIGH;
					end
				end
				SFSR_H_HIGH: begin
					div <= 4'(div + 4'h1);
					if (div == 4'(DIV_HALF - 1)) begin
						div <= 4'h0;
						if (bit_i < obits) osh <= {osh[46:0], 1'b0};
						// sampled late in the high phase: falling-edge data needs two synchronisers
						if (bit_i >= obits) rsh <= next_rsh;
						bit_i <= 7'(bit_i + 7'h1);
						st <= SFSR_H_LOW;
						if (bit_i >= obits && ((dual && bit_i[1:0] == 2'(obits + 7'd3)) ||
							(!dual && bit_i[2:0] == 3'(obits + 7'd7)))) begin
							rdat <= next_rsh;
							bcnt <= 8'(bcnt + 8'h1);
							if (bcnt + 8'h1 >= nbytes) st <= SFSR_H_END; // [RULE16]
						end else if (bit_i + 7'h1 == obits && (nbytes == 8'h0 || cmd == SFSR_CMD_WRITE_ENABLE_CMD ||
							cmd == SFSR_CMD_STATUS_WRITE_CMD || cmd == SFSR_CMD_RAW)) begin
							st <= SFSR_H_END;
						end
					end
				end
				SFSR_H_END: begin
					div <= 4'(div + 4'h1);
					if (div == 4'(DIV_HALF - 1)) begin
						st   <= SFSR_H_IDLE;
						done <= 1'b1;
					end
				end
				default: st <= SFSR_H_IDLE;
			endcase
		end
	end
	// ==========================================================
	// pins: input released during the data phase of reads [RULE21]
	assign lnk.cs_n     = (st == SFSR_H_IDLE) || (st == SFSR_H_END);
	assign lnk.sck      = (st == SFSR_H_HIGH);
	assign lnk.io0_h    = osh[47];
	assign lnk.io0_h_oe = (st != SFSR_H_IDLE) && (st != SFSR_H_END) && (bit_i < obits);
	assign lnk.wp_n     = wp_n;
endmodule // sfsr_host

// ==== sfsr_if.sv ====
// serial link between host controller and flash device
`timescale 1ns/1ps
interface sfsr_if;
	logic cs_n;
	logic sck;
	logic io0_h;
	logic io0_h_oe;
	logic io0_d;
	logic io0_d_oe;
	logic io1_d;
	logic io1_d_oe;
	logic wp_n;
	logic io0;
	logic io1;
	assign io0 = io0_h_oe ? io0_h : (io0_d_oe ? io0_d : 1'b1);
	assign io1 = io1_d_oe ? io1_d : 1'b1;
	modport dev (input cs_n, input sck, input io0, input wp_n,
		output io0_d, output io0_d_oe, output io1_d, output io1_d_oe);
	modport host (output cs_n, output sck, output io0_h, output io0_h_oe, output wp_n,
		input io0, input io1);
endinterface

// ==== sfsr_link_properties.sv ====
// concurrent checks on the serial link between the host and flash ends
`timescale 1ns/1ps
module sfsr_link_properties (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic io0_h,
	input wire logic io0_h_oe,
	input wire logic io0_d,
	input wire logic io0_d_oe,
	input wire logic io1_d,
	input wire logic io1_d_oe,
	input wire logic wp_n,
	input wire logic io0,
	input wire logic io1
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// ==========================================================
	// device side
	// window allows for the synchroniser lag behind chip select
	a_cs_rise_release: assert property ($rose(cs_n) |-> ##[0:6] !(io0_d_oe || io1_d_oe))
		else $error("device drives data after chip select rise");
	a_dual_pair_drive: assert property (io0_d_oe |-> io1_d_oe)
		else $error("io0 driven without io1");
	a_out_on_fall: assert property (io1_d_oe && $past(io1_d_oe) && $changed(io1_d) |-> !sck)
		else $error("device output changed while clock high");
	a_drive_in_frame: assert property ($rose(io1_d_oe) |-> !cs_n)
		else $error("device started driving outside a frame");

	// ==========================================================
	// host side
	a_no_io0_clash: assert property (io0_d_oe |-> !io0_h_oe)
		else $error("both ends drive io0");
	a_cs_edge_sck_low: assert property ($changed(cs_n) |-> !sck)
		else $error("chip select moved with clock high");
	a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("clock runs outside a frame");
	a_sck_high_span: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("clock high phase not four cycles");
endmodule // sfsr_link_properties

// ==== sfsr_pkg.sv ====
// shared constants and types for the serial flash status/read command block
package sfsr_pkg;
	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
	localparam logic [7:0] OP_STATUS_WRITE_CMD     = 8'h01;
	localparam logic [7:0] OP_RDSR     = 8'h05;
	localparam logic [7:0] OP_READ_SUSPEND_STATUS_CMD    = 8'h09;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_FREAD    = 8'h0b;
	localparam logic [7:0] OP_DREAD    = 8'h3b;
	localparam logic [7:0] OP_SUSPEND  = 8'hb0;
	localparam logic [7:0] OP_RESUME   = 8'h30;
	localparam logic [7:0] OP_RSTEN    = 8'h66;
	localparam logic [7:0] OP_RST      = 8'h99;
	// ==========================================================
	// suspend status byte fields
	localparam int SS_BUSY = 7;
	localparam int SS_FAIL = 5;
	localparam int SS_PSUS = 3;
	localparam int SS_ESUS = 2;
	localparam int SS_WEL  = 1;
	localparam logic [7:0] SS_RSVD_MASK = 8'h51;
	// main status byte fields
	localparam int SR_BUSY = 0;
	localparam int SR_WEL  = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_SRP  = 7;
	localparam logic [7:0] SR_WR_MASK = 8'hbc;
	localparam logic [7:0] SR_RESET   = 8'h00;
	// ==========================================================
	// sizes and timing
	localparam int ADDR_W     = 24;
	localparam int MEM_W      = 8;
	localparam int MEM_DEPTH  = 256;
	localparam int DUMMY_BITS = 8;
	localparam int CLK_NS     = 100;
	localparam int TW_NS      = 5000;
	localparam int TW_CYC     = (TW_NS + CLK_NS - 1) / CLK_NS;
	localparam int OP_NS      = 3000;
	localparam int OP_CYC     = (OP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_HALF   = 4;
	localparam logic [23:0] ADDR_TOP = 24'hffffff;
	// ==========================================================
	// host command codes
	typedef enum logic [2:0] {
		SFSR_CMD_WRITE_ENABLE_CMD  = 3'h0,
		SFSR_CMD_STATUS_WRITE_CMD  = 3'h1,
		SFSR_CMD_RDSR  = 3'h2,
		SFSR_CMD_READ_SUSPEND_STATUS_CMD = 3'h3,
		SFSR_CMD_READ  = 3'h4,
		SFSR_CMD_FREAD = 3'h5,
		SFSR_CMD_DREAD = 3'h6,
		SFSR_CMD_RAW   = 3'h7
	} sfsr_cmd_t;
	// host register map
	localparam logic [3:0] HR_CTRL   = 4'h0;
	localparam logic [3:0] HR_ADDR   = 4'h1;
	localparam logic [3:0] HR_WDATA  = 4'h2;
	localparam logic [3:0] HR_RDATA  = 4'h3;
	localparam logic [3:0] HR_STATUS = 4'h4;
endpackage

// ==== sfsr_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sfsr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	// level
	input  wire logic d_i,
	output logic      q_o
);
	logic stage1;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stage1 <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			stage1 <= d_i;
			q_o    <= stage1;
		end
	end
endmodule // sfsr_sync
